// ===== logic/osc_gate_pkg.sv
// Constants for the standby-controlled clock gating block.
// Assumes a single 100 MHz system clock and synchronous active-high reset.

package osc_gate_pkg;

    // =====================================================================
    // Clock and timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned START_MAX_MS  = 150;
    localparam int unsigned RESUME_MAX_MS = 3;
    localparam int unsigned START_CYC     = (START_MAX_MS * (CLK_HZ / 1000));
    localparam int unsigned RESUME_CYC    = (RESUME_MAX_MS * (CLK_HZ / 1000));
    // Ready delays (cycles of internal warm-up); must stay under the limits above
    localparam int unsigned START_READY_DEF  = 7_500_000;
    localparam int unsigned RESUME_READY_DEF = 200_000;

    // =====================================================================
    // Output divider: fixed factory frequency, 1..26 MHz window
    localparam int unsigned FOUT_MIN_HZ = 1_000_000;
    localparam int unsigned FOUT_MAX_HZ = 26_000_000;
    localparam int unsigned HALF_DIV_DEF = 5;  // 10 MHz output from 100 MHz
    localparam int unsigned DIV_W        = 6;

    // =====================================================================
    // Mode states
    typedef enum logic [2:0] {
        POWERUP,
        STARTUP,
        ACTIVE,
        STANDBY,
        RESUME
    } mode_e;

endpackage : osc_gate_pkg

// ===== logic/clk_div_gen.sv
// Fixed-ratio clock generator with a glitch-free gate.
// Assumes the gate request comes from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module clk_div_gen #(
    parameter int unsigned HALF_DIV = osc_gate_pkg::HALF_DIV_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      clk_o,
    output logic      gated_o
);
    localparam logic [osc_gate_pkg::DIV_W-1:0] LAST =
        osc_gate_pkg::DIV_W'(HALF_DIV - 1);

    logic [osc_gate_pkg::DIV_W-1:0] cnt_r;
    logic                           phase_r;
    logic                           gate_r;
    logic                           out_r;
    wire                            wrap = (cnt_r == LAST);
    // The gate may change only at a wrap with phase low, so every pulse is full
    wire                            boundary = wrap && !phase_r;

    // =====================================================================
    // Free-running divider; the ratio is a build constant only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r   <= '0;
            phase_r <= 1'b0;
        end else begin
            cnt_r <= wrap ? '0 : cnt_r + 1'b1;
            if (wrap) begin
                phase_r <= ~phase_r;
            end
        end
    end

    // Gate opens/closes only at a rising boundary: first period is whole
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_r <= 1'b0;
            out_r  <= 1'b0;
        end else begin
            if (boundary) begin
                gate_r <= run_i;
            end
            out_r <= (boundary ? run_i : gate_r) & (wrap ? ~phase_r : phase_r);
        end
    end

    assign clk_o   = out_r;
    assign gated_o = gate_r;

    // Output is already low when the gate closes; a high never ends early
    // A fall forced by reset is not a runt; the past term masks that cycle
    a_no_runt_high : assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(out_r) && !$past(rst_i) |-> $past(phase_r) && $past(wrap))
        else $error("output fell away from a half-period boundary");
    a_stop_low : assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(gate_r) |-> !out_r)
        else $error("gate closed with output high");
endmodule : clk_div_gen
`default_nettype wire

// ===== logic/osc_standby_ctrl.sv
// Mode control of a fixed-frequency clock source with standby gating.
// Assumes standby_select_i is already synchronous to clk_i; a floating
// pin is resolved low by the pad pull-down before this block.
`timescale 1ns/10ps
`default_nettype none
module osc_standby_ctrl #(
    parameter int unsigned START_READY  = osc_gate_pkg::START_READY_DEF,
    parameter int unsigned RESUME_READY = osc_gate_pkg::RESUME_READY_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic standby_select_i,
    output logic      clk_out_o,
    output logic      clk_out_oe_n_o,
    output logic      pulldown_strong_o,
    output logic      core_power_o,
    output logic      standby_o
);
    localparam int unsigned CNT_W = 24;

    osc_gate_pkg::mode_e mode_r;
    osc_gate_pkg::mode_e mode_nxt;
    logic [CNT_W-1:0]    cnt_r;
    logic [CNT_W-1:0]    cnt_nxt;
    logic                gen_clk;
    logic                gen_gated;

    // =====================================================================
    // Decode of the select and of the warm-up counters
    wire sel_high   = standby_select_i;
    wire start_done = (cnt_r >= CNT_W'(START_READY));
    wire res_done   = (cnt_r >= CNT_W'(RESUME_READY));
    wire run_req    = (mode_r == osc_gate_pkg::ACTIVE);

    // Rated limits less one output period of gate slack, for the checks
    wire start_in_time  = (cnt_r < CNT_W'(osc_gate_pkg::START_CYC
                                          - 2 * osc_gate_pkg::HALF_DIV_DEF - 1));
    wire resume_in_time = (cnt_r < CNT_W'(osc_gate_pkg::RESUME_CYC
                                          - 2 * osc_gate_pkg::HALF_DIV_DEF - 1));

    // Next-state: power-up waits for low select, standby always via resume
    always_comb begin
        mode_nxt = mode_r;
        cnt_nxt  = cnt_r + 1'b1;
        case (mode_r)
            osc_gate_pkg::POWERUP: begin
                cnt_nxt = '0;
                if (!sel_high) begin
                    mode_nxt = osc_gate_pkg::STARTUP;
                end
            end
            osc_gate_pkg::STARTUP: begin
                if (sel_high) begin
                    mode_nxt = osc_gate_pkg::STANDBY;
                end else if (start_done) begin
                    mode_nxt = osc_gate_pkg::ACTIVE;
                end
            end
            osc_gate_pkg::ACTIVE: begin
                cnt_nxt = '0;
                if (sel_high) begin
                    mode_nxt = osc_gate_pkg::STANDBY;
                end
            end
            osc_gate_pkg::STANDBY: begin
                cnt_nxt = '0;
                if (!sel_high) begin
                    mode_nxt = osc_gate_pkg::RESUME;
                end
            end
            osc_gate_pkg::RESUME: begin
                if (sel_high) begin
                    mode_nxt = osc_gate_pkg::STANDBY;
                end else if (res_done) begin
                    mode_nxt = osc_gate_pkg::ACTIVE;
                end
            end
            default: begin
                mode_nxt = osc_gate_pkg::POWERUP;
                cnt_nxt  = '0;
            end
        endcase
    end

    // =====================================================================
    // Mode register; reset stands for power-on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= osc_gate_pkg::POWERUP;
            cnt_r  <= '0;
        end else begin
            mode_r <= mode_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // Output generator; gate waits for the next full period boundary
    clk_div_gen #(
        .HALF_DIV (osc_gate_pkg::HALF_DIV_DEF)
    ) u_gen (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (run_req),
        .clk_o   (gen_clk),
        .gated_o (gen_gated)
    );

    // =====================================================================
    // Pad controls: driver off when gated; weak pull-down only in standby
    assign clk_out_o         = gen_clk;
    // Driver held on until the gate has closed low, avoiding a cut high
    assign clk_out_oe_n_o    = !gen_gated;
    assign pulldown_strong_o = !standby_o;
    // Synthesizer powered outside standby and power-up; reference and watcher never gated
    assign core_power_o      = (mode_r != osc_gate_pkg::STANDBY)
                            && (mode_r != osc_gate_pkg::POWERUP);
    assign standby_o         = (mode_r == osc_gate_pkg::STANDBY);

    // =====================================================================
    // Checks
    // Select seen high in standby, then seen low while still in standby
    sequence s_standby_low;
        (mode_r == osc_gate_pkg::STANDBY) && standby_select_i
        ##1 (mode_r == osc_gate_pkg::STANDBY) && !standby_select_i;
    endsequence

    // Gate request held for one whole output period (ten cycles at HALF_DIV 5)
    sequence s_run_held;
        run_req[*8] ##1 run_req[*2];
    endsequence

    // Gate request withdrawn for one whole output period
    sequence s_stop_held;
        (!run_req)[*8] ##1 (!run_req)[*2];
    endsequence

    // Low select never drops an active output
    a_low_active : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::ACTIVE) && !standby_select_i
        |=> mode_r == osc_gate_pkg::ACTIVE)
        else $error("active mode left with select low");

    // High select wins from every mode past power-up
    a_high_standby : assert property (@(posedge clk_i) disable iff (rst_i)
        standby_select_i && (mode_r != osc_gate_pkg::POWERUP)
        |=> mode_r == osc_gate_pkg::STANDBY)
        else $error("select high did not enter standby");

    // Synthesizer off in standby
    a_core_off : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::STANDBY) |-> !core_power_o)
        else $error("core powered in standby");

    // Active mode keeps the core and normal pad pull-down
    a_active_power : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::ACTIVE) |-> core_power_o && pulldown_strong_o && !standby_o)
        else $error("active mode without core power");

    // Only the weak pull-down holds the pin in standby
    a_standby_weak : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::STANDBY) |-> !pulldown_strong_o && standby_o)
        else $error("strong pull-down left on in standby");

    // Once the gate has had time to close, the driver is off and low
    a_gate_off : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::STANDBY) ##20 (mode_r == osc_gate_pkg::STANDBY)
        |-> clk_out_oe_n_o && !clk_out_o)
        else $error("output driven late in standby");

    // Nothing leaves the pad before the select was seen low
    a_powerup_off : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::POWERUP) |-> clk_out_oe_n_o && !clk_out_o)
        else $error("output on before select seen low");

    // Power-up waits as long as the select stays high
    a_powerup_hold : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::POWERUP) && standby_select_i
        |=> mode_r == osc_gate_pkg::POWERUP)
        else $error("power-up left with select high");

    // Startup cannot reach active before its warm-up count
    a_start_wait : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::STARTUP) && !start_done
        |=> mode_r != osc_gate_pkg::ACTIVE)
        else $error("startup ended before blocks ready");

    // Gate request only follows a completed warm-up
    a_enable_ready : assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(run_req) |-> $past(start_done) || $past(res_done))
        else $error("output enabled before blocks ready");

    // Standby is always left through resume
    a_resume_path : assert property (@(posedge clk_i) disable iff (rst_i)
        s_standby_low |=> mode_r == osc_gate_pkg::RESUME)
        else $error("standby left without resume");

    // No gate request while resuming
    a_resume_off : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::RESUME) |-> !run_req)
        else $error("gate requested during resume");

    // Resume holds until its warm-up count
    a_resume_wait : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::RESUME) && !res_done
        |=> mode_r != osc_gate_pkg::ACTIVE)
        else $error("resume ended before blocks ready");

    // Resume finishes by itself once ready
    a_resume_end : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::RESUME) && res_done && !standby_select_i
        |=> mode_r == osc_gate_pkg::ACTIVE)
        else $error("resume did not complete to active");

    // Gate opens at the first boundary, at most one output period late
    a_gate_open : assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(run_req) ##1 s_run_held |-> gen_gated)
        else $error("gate did not open within a period");

    // Gate closes at the first boundary, leaving the output low
    a_gate_close : assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(run_req) ##1 s_stop_held |-> !gen_gated && !gen_clk)
        else $error("gate did not close low within a period");

    // Warm-up count leaves room for the gate inside the rated startup time
    a_start_limit : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::STARTUP) |-> start_in_time)
        else $error("startup overran its time limit");

    // Same margin for the rated resume time
    a_resume_limit : assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == osc_gate_pkg::RESUME) |-> resume_in_time)
        else $error("resume overran its time limit");
endmodule : osc_standby_ctrl
`default_nettype wire

// ===== dv/host_select_model.sv
// Host-side model that drives the standby select level of the block.
// Assumes one clock shared with the block; the pin never floats here.
`timescale 1ns/10ps
`default_nettype none
// =====================================
// Host select driver
module host_select_model (
    input  wire logic clk_i,
    input  wire logic want_standby_i,
    input  wire logic slow_i,
    output logic      standby_select_o = 1'b1
);
    logic [2:0] lag_r = 3'h0;

    // A slow host lets a new level wait eight cycles before it lands
    always @(posedge clk_i) begin
        if (want_standby_i == standby_select_o || !slow_i || lag_r == 3'h7) begin
            standby_select_o <= want_standby_i;
            lag_r            <= 3'h0;
        end else begin
            lag_r <= lag_r + 3'h1;
        end
    end
endmodule : host_select_model
`default_nettype wire

// ===== dv/oscillator_standby_gating_bench.sv
// Self-checking bench for the standby gated clock block.
// Assumes short ready counts; host model drives the select pin.
`timescale 1ns/10ps
`default_nettype none
// =====================================
// Bench top
module oscillator_standby_gating_bench;
    localparam int unsigned START_RDY  = 40;
    localparam int unsigned RESUME_RDY = 20;
    localparam logic [3:0]  OPEN       = 4'h3;  // oe_n, standby, power, strong pull
    localparam logic [3:0]  CLOSE      = 4'hc;
    logic       clk_i        = 1'b0;
    logic       rst_i        = 1'b1;
    logic       want_standby = 1'b1;
    logic       slow         = 1'b0;
    wire logic  sel;
    wire logic  clk_out, oe_n, pd_strong, core_pwr, standby;
    int         err_count    = 0;
    int         tests_run    = 0;
    int         run          = 0;
    logic       prev_oe      = 1'b1;
    logic       prev_clk     = 1'b0;
    logic       gate_open    = 1'b0;
    logic [3:0] exp_note;
    logic [3:0] note_q[$];

    always #5 clk_i = ~clk_i;

    host_select_model host_select_model_inst (.clk_i(clk_i), .want_standby_i(want_standby),
        .slow_i(slow), .standby_select_o(sel));
    osc_standby_ctrl #(.START_READY(START_RDY), .RESUME_READY(RESUME_RDY)) osc_standby_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .standby_select_i(sel), .clk_out_o(clk_out),
        .clk_out_oe_n_o(oe_n), .pulldown_strong_o(pd_strong), .core_power_o(core_pwr),
        .standby_o(standby));

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task tally_and_finish;
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Ask the host for a level, return once the block samples it
    task apply(input logic lvl, input logic slw);
        int n;
        @(posedge clk_i);
        want_standby <= lvl;
        slow         <= slw;
        n = 0;
        while (sel !== lvl && n < 16) begin
            @(posedge clk_i);
            n++;
        end
    endtask : apply

    // Note the expected gate state, then bound the wait for it
    task wait_gate(input logic [3:0] note, input int lo, input int hi);
        int n;
        note_q.push_back(note);
        n = 0;
        while (oe_n !== note[3] && n <= hi) begin
            @(posedge clk_i);
            n++;
        end
        check(n >= lo && n <= hi, 1);
    endtask : wait_gate

    // Monitor: a gate change takes the oldest note; open pulses must be full width
    always @(negedge clk_i) begin
        if (rst_i) begin
            gate_open = 1'b0;
        end else if (oe_n !== prev_oe) begin
            exp_note = (note_q.size() > 0) ? note_q.pop_front() : ~{oe_n, standby, core_pwr, pd_strong};
            check({oe_n, standby, core_pwr, pd_strong}, exp_note);
            check(clk_out, !oe_n);
            gate_open = !oe_n;
            run = 0;
        end else if (gate_open && clk_out !== prev_clk) begin
            check(run, osc_gate_pkg::HALF_DIV_DEF);
            run = 0;
        end
        prev_oe  = oe_n;
        prev_clk = clk_out;
        run++;
    end

    // Main sequence: power-up, modes, aborted resume, random toggling, reset
    initial begin
        void'($urandom(32'h0000_e476));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (START_RDY + 20) @(posedge clk_i);
        check({oe_n, core_pwr}, 2'b10);
        apply(1'b0, 1'b0);
        wait_gate(OPEN, START_RDY, START_RDY + 14);
        repeat (60) @(posedge clk_i);
        apply(1'b1, 1'b0);
        wait_gate(CLOSE, 1, 12);
        apply(1'b0, 1'b0);
        repeat (5) @(posedge clk_i);
        apply(1'b1, 1'b1);
        repeat (RESUME_RDY + 20) @(posedge clk_i);
        check({oe_n, standby}, 2'b11);
        for (int i = 0; i < 6; i++) begin
            apply(1'b0, 1'($urandom));
            wait_gate(OPEN, RESUME_RDY + 1, RESUME_RDY + 14);
            repeat ($urandom_range(60, 20)) @(posedge clk_i);
            apply(1'b1, 1'($urandom));
            wait_gate(CLOSE, 1, 12);
            repeat ($urandom_range(40, 10)) @(posedge clk_i);
        end
        apply(1'b0, 1'b0);
        wait_gate(OPEN, RESUME_RDY + 1, RESUME_RDY + 14);
        repeat (30) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check(oe_n, 1);
        wait_gate(OPEN, START_RDY, START_RDY + 14);
        repeat (30) @(posedge clk_i);
        // Startup cut short by a high select must fall to standby, then resume
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        apply(1'b1, 1'b0);
        repeat (START_RDY + 20) @(posedge clk_i);
        check({oe_n, standby, core_pwr}, 3'b110);
        apply(1'b0, 1'b0);
        wait_gate(OPEN, RESUME_RDY + 1, RESUME_RDY + 14);
        repeat (30) @(posedge clk_i);
        tally_and_finish;
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        tally_and_finish;
    end
endmodule : oscillator_standby_gating_bench
`default_nettype wire
